/* File: rtl/xpoint_defines.svh */
// Constants for the eight-way crosspoint switch.
`ifndef XPOINT_DEFINES_SVH
`define XPOINT_DEFINES_SVH
`define XP_PORTS 8
`define XP_SEL_W 3
`define XP_BYTE_W 8
`define XP_OUT_RST 8'h00
`define XP_FIFO_DEPTH 16
`define XP_SETUP_NS 17
`define XP_CLK_PERIOD_NS 5
`define XP_SETUP_CYCLES ((`XP_SETUP_NS + `XP_CLK_PERIOD_NS - 1) / `XP_CLK_PERIOD_NS)
`endif

/* File: rtl/xpoint_pkg.sv */
// Types shared by the crosspoint switch files.
package xpoint_pkg;
	typedef struct packed {
		logic [2:0] in_sel;
		logic [2:0] out_sel;
		logic [7:0][7:0] data;
	} route_req_t;
	typedef struct packed {
		logic [7:0][7:0] outs;
		logic [7:0][7:0] latched;
	} xp_state_t;
endpackage : xpoint_pkg

/* File: rtl/xpoint_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module xpoint_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_state_t;
	fifo_state_t st;
	fifo_state_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;
	assign in_ready = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign push = in_valid && in_ready && ce;
	assign pop = out_valid && out_ready && ce;
	assign out_data = mem[st.rp];
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wp = st.wp + 1'b1;
		end
		if (pop) begin
			next_st.rp = st.rp + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[st.wp] <= in_data;
		end
	end
	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (sys_rst)
		st.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
endmodule : xpoint_fifo
`default_nettype wire

/* File: rtl/crosspoint_switch.sv */
// Eight-input, eight-output byte-wide crosspoint switch with hold and latches.
// How it works
// - Input select code picks one data input.
// - Output select code names one output.
// - Shared chosen term gated by output match.
// - New routing lands at next clock edge on registered outputs, at once on comb outputs.
// - Hold keeps unaddressed outputs at old value.
// - Next is held AND not-match OR gated.
// - Optional input latches on data inputs, loaded at the clock edge while latch_open.
// - Outputs registered or combinational per option.
// - Byte built from parallel bit slices.
`include "xpoint_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module crosspoint_switch
	import xpoint_pkg::*;
#(
	parameter int WIDTH = `XP_BYTE_W,
	parameter int FIFO_DEPTH = `XP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hold_en,
	input wire logic latch_en,
	input wire logic latch_open,
	input wire logic comb_out,
	input wire logic req_valid,
	output logic req_ready,
	input wire route_req_t req,
	output logic [7:0][7:0] switch_out,
	output logic [7:0] chosen_input_term
);
	route_req_t fifo_out;
	logic fifo_valid;
	xp_state_t st;
	xp_state_t next_st;
	logic [7:0][7:0] data_eff;
	logic [7:0] match;
	logic [7:0][7:0] comb_val;
	// The FIFO absorbs bursts of routing requests, so the driver only meets setup at its port.
	xpoint_fifo #(
		.WIDTH($bits(route_req_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(fifo_valid),
		.out_ready(1'b1),
		.out_data(fifo_out)
	);
	function automatic logic [7:0] onehot3(input logic [2:0] code);
		logic [7:0] r;
		r = 8'h00;
		r[code] = 1'b1;
		return r;
	endfunction : onehot3
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			data_eff[i] = latch_en ? st.latched[i] : fifo_out.data[i];
		end
		chosen_input_term = data_eff[fifo_out.in_sel];
		match = fifo_valid ? onehot3(fifo_out.out_sel) : 8'h00;
		next_st = st;
		for (int i = 0; i < 8; i++) begin
			if (latch_open) begin
				next_st.latched[i] = fifo_out.data[i];
			end
			// Without hold an unaddressed output reads zero, as the plain gated form does.
			next_st.outs[i] = ({8{hold_en & ~match[i]}} & st.outs[i])
				| ({8{match[i]}} & chosen_input_term);
			comb_val[i] = next_st.outs[i];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
	// The combinational path trades glitch-free outputs for zero latency.
	assign switch_out = comb_out ? comb_val : st.outs;
	a_route_next_edge: assert property (@(posedge clk) disable iff (sys_rst)
		ce && fifo_valid |=> st.outs[$past(fifo_out.out_sel)] == $past(chosen_input_term))
		else $error("Addressed output did not take the chosen input.");
	a_hold_keeps: assert property (@(posedge clk) disable iff (sys_rst)
		ce && hold_en && !match[0] |=> st.outs[0] == $past(st.outs[0]))
		else $error("Held output changed.");
	a_nohold_clears: assert property (@(posedge clk) disable iff (sys_rst)
		ce && !hold_en && !match[7] |=> st.outs[7] == 8'h00)
		else $error("Unaddressed output not cleared without hold.");
	a_reset_clears: assert property (@(posedge clk)
		sys_rst |=> st.outs == '0)
		else $error("Reset left an output set.");
	a_match_onehot: assert property (@(posedge clk) disable iff (sys_rst)
		$countones(match) <= 1)
		else $error("More than one output addressed.");
	a_select_input: assert property (@(posedge clk) disable iff (sys_rst)
		!latch_en |-> chosen_input_term == fifo_out.data[fifo_out.in_sel])
		else $error("Wrong input chosen.");
	a_comb_path: assert property (@(posedge clk) disable iff (sys_rst)
		comb_out && fifo_valid && !latch_en
		|-> switch_out[fifo_out.out_sel] == fifo_out.data[fifo_out.in_sel])
		else $error("Combinational output mismatch.");
	a_latch_capture: assert property (@(posedge clk) disable iff (sys_rst)
		ce && latch_open |=> st.latched == $past(fifo_out.data))
		else $error("Latch did not capture input.");
endmodule : crosspoint_switch
`default_nettype wire

/* File: test/route_driver.sv */
// Model of the logic that feeds route requests to the switch.
`timescale 1ns/100ps
`default_nettype none
module route_driver
	import xpoint_pkg::*;
(
	input wire logic clk,
	input wire logic req_ready,
	output logic req_valid,
	output route_req_t req
);
	initial begin
		req_valid = 1'h0;
		req = '1;
	end
	task automatic send(input route_req_t r);
		req <= r;
		req_valid <= 1'h1;
		do @(posedge clk); while (req_ready !== 1'h1);
	endtask : send
	task automatic idle();
		req_valid <= 1'h0;
		req <= ~req; // Released lines must not keep the old value.
	endtask : idle
endmodule : route_driver
`default_nettype wire

/* File: test/crosspoint_switch_tb.sv */
// Self-checking bench for the crosspoint switch.
`timescale 1ns/100ps
`default_nettype none
module crosspoint_switch_tb
	import xpoint_pkg::*;
;
	logic clk, sys_rst, ce, hold_en, req_valid, req_ready;
	route_req_t req;
	logic [7:0][7:0] switch_out, exp_out, data;
	logic latch_en, latch_open, comb_out;
	logic [7:0] chosen;
	int error_cnt = 0;
	int check_count = 0;
	crosspoint_switch u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hold_en(hold_en),
		.latch_en(latch_en), .latch_open(latch_open), .comb_out(comb_out),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .switch_out(switch_out),
		.chosen_input_term(chosen));
	route_driver u_drv (.clk(clk), .req_ready(req_ready), .req_valid(req_valid), .req(req));
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic all_routes();
		hold_en <= 1'h1;
		for (int k = 0; k < 8; k++) begin
			u_drv.send({k[2:0], 3'(7 - k), data});
			exp_out[7 - k] = data[k];
		end
		u_drv.idle();
		repeat (3) @(posedge clk);
		#1 check("held routes", exp_out, switch_out);
	endtask : all_routes
	task automatic no_hold();
		hold_en <= 1'h0;
		u_drv.send({3'h3, 3'h0, data});
		u_drv.idle();
		exp_out = '0;
		exp_out[0] = data[3];
		@(posedge clk);
		#1 check("unheld route", exp_out, switch_out);
		@(posedge clk);
		#1 check("unheld clear", '0, switch_out);
	endtask : no_hold
	task automatic latch_comb();
		comb_out <= 1'h1;
		latch_open <= 1'h1;
		hold_en <= 1'h1;
		u_drv.send({3'h1, 3'h2, data});
		u_drv.idle();
		#1 check("comb chosen", {56'h0, data[1]}, {56'h0, chosen});
		check("comb output", {56'h0, data[1]}, {56'h0, switch_out[2]});
		@(posedge clk);
		latch_open <= 1'h0;
		latch_en <= 1'h1;
		comb_out <= 1'h0;
		u_drv.send({3'h4, 3'h6, ~data});
		u_drv.idle();
		#1 check("latched chosen", {56'h0, data[4]}, {56'h0, chosen});
		@(posedge clk);
		#1 check("latched route", {56'h0, data[4]}, {56'h0, switch_out[6]});
		check("held comb route", {56'h0, data[1]}, {56'h0, switch_out[2]});
		@(posedge clk);
		latch_en <= 1'h0;
		sys_rst <= 1'h1;
		@(posedge clk);
		sys_rst <= 1'h0;
		#1 check("mid reset outputs", '0, switch_out);
	endtask : latch_comb
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// The whole run needs well under a hundred cycles.
	initial begin
		#5000;
		error_cnt++;
		test_done();
	end
	initial begin
		sys_rst = 1'h1;
		ce = 1'h1;
		hold_en = 1'h1;
		latch_en = 1'h0;
		latch_open = 1'h0;
		comb_out = 1'h0;
		data = 64'hF7E6D5C4B3A29180;
		exp_out = '0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		#1 check("reset outputs", '0, switch_out);
		@(posedge clk);
		all_routes();
		@(posedge clk);
		no_hold();
		@(posedge clk);
		latch_comb();
		test_done();
	end
endmodule : crosspoint_switch_tb
`default_nettype wire
